/* File: rtl/adc_channel_start_control.sv */
// Converter control: registers, channel routing, power and start/done sequencing
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_channel_start_control
    import adc_ctrl_pkg::*;
#(
    parameter int RESULT_WIDTH = 12,
    parameter int SETTLE_CYCLES = `SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic                    CLK_I,
    input  wire logic                    RST_I,
    // Register port
    input  wire logic [3:0]              ADDR_I,
    input  wire logic [7:0]              WDATA_I,
    input  wire logic                    WR_I,
    input  wire logic                    RD_I,
    output logic      [7:0]              RDATA_O,
    // Converter core
    output logic                         CONV_POWER_O,
    output logic                         CONV_START_O,
    input  wire logic                    CONV_DONE_I,
    input  wire logic [RESULT_WIDTH-1:0] CONV_RESULT_I,
    input  wire logic                    CONV_SIGN_I,
    // Analog multiplexer routing
    output logic      [4:0]              POS_SEL_O,
    output logic                         POS_PIN_O,
    output logic                         POS_INTERNAL_O,
    output logic      [2:0]              NEG_SEL_O,
    output logic                         NEG_GROUND_O,
    output logic      [7:0]              REF_TRIG_CFG_O,
    output logic      [7:0]              CLK_ACQ_CFG_O,
    // Interrupt
    output logic                         IRQ_O
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Sign copies that pad the result out to the 16-bit pair
    localparam int SIGN_WIDTH = 16 - RESULT_WIDTH;
    logic [7:0]              ctrl_zero_q;
    logic [7:0]              ctrl_one_q;
    logic [7:0]              ctrl_two_q;
    logic [15:0]             result_q;
    logic                    small_pkg_q;
    logic [`IRQ_WIDTH-1:0]   irq_status_q;
    logic [`IRQ_WIDTH-1:0]   irq_enable_q;
    logic [7:0]              rdata_q;
    conv_state_t             state_q;
    conv_state_t             state_d;
    logic [15:0]             settle_q;
    logic                    done_s1_q;
    logic                    done_s2_q;
    logic                    done_prev_q;
    logic                    done_rise;
    logic [RESULT_WIDTH-1:0] result_s1_q;
    logic [RESULT_WIDTH-1:0] result_s2_q;
    logic                    sign_s1_q;
    logic                    sign_s2_q;
    logic                    wr_zero;
    logic                    start_req;
    logic                    start_ok;
    logic                    start_ign;
    logic                    finish;
    logic                    powered;
    logic                    pin_sel;
    logic                    internal_sel;
    logic                    ch_implemented;
    logic [15:0]             result_d;
    logic [`IRQ_WIDTH-1:0]   irq_set;

    // ----------------------------------------------------------------
    // Channel decode
    // ----------------------------------------------------------------
    channel_decode u_decode
    (
        .sel_i         (ctrl_zero_q[`CZ_SEL_MSB:`CZ_SEL_LSB]),
        .small_pkg_i   (small_pkg_q),
        .pin_sel_o     (pin_sel),
        .internal_o    (internal_sel),
        .implemented_o (ch_implemented)
    );

    // ----------------------------------------------------------------
    // Write decode and start qualification
    // ----------------------------------------------------------------
    assign wr_zero   = WR_I && (ADDR_I == `OFS_CTRL_ZERO);
    // A go written while busy is dropped, so a running conversion never restarts
    assign start_req = wr_zero && WDATA_I[`CZ_GO_BIT] && (state_q == ST_IDLE);
    // Power is taken from the same write so on and go may be set together
    assign start_ok  = start_req && WDATA_I[`CZ_ON_BIT];
    assign start_ign = start_req && !WDATA_I[`CZ_ON_BIT];
    assign powered   = ctrl_zero_q[`CZ_ON_BIT];

    // Done pin comes from the analog side: two-stage synchroniser then edge
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            done_s1_q   <= 1'b0;
            done_s2_q   <= 1'b0;
            done_prev_q <= 1'b0;
        end
        else
        begin
            done_s1_q   <= CONV_DONE_I;
            done_s2_q   <= done_s1_q;
            done_prev_q <= done_s2_q;
        end
    end

    // Result and sign cross in step with done; the core holds them while done is high
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            result_s1_q <= '0;
            result_s2_q <= '0;
            sign_s1_q   <= 1'b0;
            sign_s2_q   <= 1'b0;
        end
        else
        begin
            result_s1_q <= CONV_RESULT_I;
            result_s2_q <= result_s1_q;
            sign_s1_q   <= CONV_SIGN_I;
            sign_s2_q   <= sign_s1_q;
        end
    end

    assign done_rise = done_s2_q && !done_prev_q;
    // Completion only counts once the start was issued; losing power aborts
    assign finish    = (state_q == ST_WAIT) && done_rise;

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (start_ok)
                    state_d = ST_REQ;
            ST_REQ:
                if (!powered)
                    state_d = ST_IDLE;
                else if (settle_q == 16'h0000)
                    state_d = ST_WAIT;
            ST_WAIT:
                if (!powered || finish)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Settle counter holds off the start pulse after power is applied
    // Reloaded on every start, so an already powered converter also waits
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            settle_q <= 16'h0000;
        else if (start_ok)
            settle_q <= 16'(SETTLE_CYCLES - 1);
        else if ((state_q == ST_REQ) && (settle_q != 16'h0000))
            settle_q <= settle_q - 16'h0001;
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Control zero: bit 7 never stored, busy bit owned by the sequencer
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ctrl_zero_q <= `RST_CTRL;
        else
        begin
            if (wr_zero)
            begin
                ctrl_zero_q[`CZ_SEL_MSB:`CZ_SEL_LSB] <= WDATA_I[`CZ_SEL_MSB:`CZ_SEL_LSB];
                ctrl_zero_q[`CZ_ON_BIT]              <= WDATA_I[`CZ_ON_BIT];
            end
            ctrl_zero_q[7] <= 1'b0;
            // Busy drops on completion, on loss of power or on a refused start
            if (start_ok)
                ctrl_zero_q[`CZ_GO_BIT] <= 1'b1;
            else if (finish || (state_q != ST_IDLE && !powered) || start_ign)
                ctrl_zero_q[`CZ_GO_BIT] <= 1'b0;
        end
    end

    // Control one: reference, trigger and negative select
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ctrl_one_q <= `RST_CTRL;
        else if (WR_I && (ADDR_I == `OFS_CTRL_ONE))
            ctrl_one_q <= WDATA_I;
    end

    // Control two: format, acquisition time and clock source
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ctrl_two_q <= `RST_CTRL;
        else if (WR_I && (ADDR_I == `OFS_CTRL_TWO))
            ctrl_two_q <= WDATA_I & `CT_WRITE_MASK;
    end

    // Package strap register: one selects the 16-input variant
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            small_pkg_q <= 1'b0;
        else if (WR_I && (ADDR_I == `OFS_PKG_SEL))
            small_pkg_q <= WDATA_I[0];
    end

    // ----------------------------------------------------------------
    // Result formatting
    // ----------------------------------------------------------------
    // Sign replicated into four bits; left puts sign low, right puts it high
    always_comb
    begin
        if (ctrl_two_q[`CT_FMT_BIT])
            result_d = {{SIGN_WIDTH{sign_s2_q}}, result_s2_q};
        else
            result_d = {result_s2_q, {SIGN_WIDTH{sign_s2_q}}};
    end

    // Loaded in the same cycle busy drops; pair doubles as storage when off
    // A completion always takes priority over a software write to the pair
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            result_q <= 16'h0000;
        else if (finish)
            result_q <= result_d;
        else if (!powered && WR_I && (ADDR_I == `OFS_RES_HIGH))
            result_q[15:8] <= WDATA_I;
        else if (!powered && WR_I && (ADDR_I == `OFS_RES_LOW))
            result_q[7:0] <= WDATA_I;
    end

    // ----------------------------------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------------------------------
    assign irq_set = {start_ign, finish};

    // Set wins over a clear written in the same cycle
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            irq_status_q <= '0;
        else if (WR_I && (ADDR_I == `OFS_IRQ_CLEAR))
            irq_status_q <= (irq_status_q & ~WDATA_I[`IRQ_WIDTH-1:0]) | irq_set;
        else
            irq_status_q <= irq_status_q | irq_set;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            irq_enable_q <= '0;
        else if (WR_I && (ADDR_I == `OFS_IRQ_ENABLE))
            irq_enable_q <= WDATA_I[`IRQ_WIDTH-1:0];
    end

    assign IRQ_O = |(irq_status_q & irq_enable_q);

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Data stands one cycle after the strobe; unmapped reads give zero
    // The clear register is write-only and falls through to zero
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            rdata_q <= 8'h00;
        else if (RD_I)
        begin
            case (ADDR_I)
                `OFS_CTRL_ZERO:  rdata_q <= ctrl_zero_q & `CZ_READ_MASK;
                `OFS_CTRL_ONE:   rdata_q <= ctrl_one_q;
                `OFS_CTRL_TWO:   rdata_q <= ctrl_two_q;
                `OFS_RES_HIGH:   rdata_q <= result_q[15:8];
                `OFS_RES_LOW:    rdata_q <= result_q[7:0];
                `OFS_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                `OFS_IRQ_ENABLE: rdata_q <= {6'h00, irq_enable_q};
                `OFS_PKG_SEL:    rdata_q <= {7'h00, small_pkg_q};
                default:         rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign RDATA_O = rdata_q;

    // ----------------------------------------------------------------
    // Converter and multiplexer outputs
    // ----------------------------------------------------------------
    // Power gate follows the on bit directly
    assign CONV_POWER_O   = powered;
    // One-cycle start once settled; any channel code is passed through
    assign CONV_START_O   = (state_q == ST_REQ) && powered && (settle_q == 16'h0000);
    assign POS_SEL_O      = ctrl_zero_q[`CZ_SEL_MSB:`CZ_SEL_LSB];
    // Reserved and absent pins route nowhere, giving an undefined result
    assign POS_PIN_O      = pin_sel && ch_implemented;
    assign POS_INTERNAL_O = internal_sel;
    assign NEG_SEL_O      = ctrl_one_q[2:0];
    assign NEG_GROUND_O   = (ctrl_one_q[2:0] == 3'h0);
    assign REF_TRIG_CFG_O = ctrl_one_q;
    assign CLK_ACQ_CFG_O  = ctrl_two_q;

endmodule

/* File: rtl/adc_ctrl_consts.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// Register offsets (byte address, 8-bit registers)
`define OFS_CTRL_ZERO   4'h0
`define OFS_CTRL_ONE    4'h1
`define OFS_CTRL_TWO    4'h2
`define OFS_RES_HIGH    4'h3
`define OFS_RES_LOW     4'h4
`define OFS_IRQ_STATUS  4'h5
`define OFS_IRQ_ENABLE  4'h6
`define OFS_IRQ_CLEAR   4'h7
`define OFS_PKG_SEL     4'h8

// Control register zero fields
`define CZ_ON_BIT       0
`define CZ_GO_BIT       1
`define CZ_SEL_LSB      2
`define CZ_SEL_MSB      6
`define CZ_WRITE_MASK   8'h7d
`define CZ_READ_MASK    8'h7f

// Control register two fields
`define CT_FMT_BIT      7
`define CT_WRITE_MASK   8'hbf

// Reset values
`define RST_CTRL        8'h00

// Positive select code map
`define SEL_LAST_PIN    5'h17
`define SEL_GAP_LO_A    5'h0c
`define SEL_GAP_HI_A    5'h0f
`define SEL_GAP_LO_B    5'h14
`define SEL_CHARGE      5'h1c
`define SEL_TEMP        5'h1d
`define SEL_CORE        5'h1e
`define SEL_BANDGAP     5'h1f

// Interrupt status bits
`define IRQ_DONE_BIT    0
`define IRQ_IGN_BIT     1
`define IRQ_WIDTH       2

// Converter power-up settle time and derived cycle count at 200 MHz
`define SETTLE_NS       20
`define CLK_MHZ         200
`define SETTLE_CYC      ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/adc_ctrl_pkg.sv */
// Types shared by the converter control design
package adc_ctrl_pkg;

    // Conversion sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_REQ  = 3'b010,
        ST_WAIT = 3'b100
    } conv_state_t;

endpackage

/* File: rtl/channel_decode.sv */
// Decodes the positive select code into a pin index or an internal source
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module channel_decode
    import adc_ctrl_pkg::*;
(
    // Selection
    input  wire logic [4:0] sel_i,
    input  wire logic       small_pkg_i,
    // Decoded routing
    output logic            pin_sel_o,
    output logic            internal_o,
    output logic            implemented_o
);

    logic in_pin_range;
    logic small_gap;

    // Codes up to 23 are pins; upper four codes are internal sources
    assign in_pin_range = (sel_i <= `SEL_LAST_PIN);
    assign small_gap    = small_pkg_i &&
                          (((sel_i >= `SEL_GAP_LO_A) && (sel_i <= `SEL_GAP_HI_A)) ||
                           ((sel_i >= `SEL_GAP_LO_B) && (sel_i <= `SEL_LAST_PIN)));

    // Pins 12-15 and 20-23 are missing on the small package
    assign pin_sel_o     = in_pin_range && !small_gap;
    assign internal_o    = (sel_i >= `SEL_CHARGE);
    assign implemented_o = pin_sel_o || (sel_i >= `SEL_TEMP);

endmodule

/* File: testbench/adc_ctrl_chk.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_ctrl_chk
    import adc_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = 4
)
(
    // Clock, reset and register port
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] RDATA_O,
    // Converter and routing
    input  wire logic       CONV_POWER_O,
    input  wire logic       CONV_START_O,
    input  wire logic [4:0] POS_SEL_O,
    input  wire logic       POS_PIN_O,
    input  wire logic       POS_INTERNAL_O,
    input  wire logic [2:0] NEG_SEL_O,
    input  wire logic       NEG_GROUND_O,
    input  wire logic [7:0] REF_TRIG_CFG_O,
    input  wire logic [7:0] CLK_ACQ_CFG_O
);
    localparam int SMAX = SETTLE_CYCLES + 3;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // Write steps seen on the register port
    sequence wr0;
        WR_I && ADDR_I == `OFS_CTRL_ZERO;
    endsequence
    sequence go_wr;
        wr0 ##0 WDATA_I[1:0] == 2'h3;
    endsequence
    sequence off_go_wr;
        wr0 ##0 WDATA_I[1:0] == 2'h2;
    endsequence

    start_lat_a: assert property (go_wr |-> ##[1:SMAX] CONV_START_O)
        else $error("no start pulse after a go write");
    refuse_off_a: assert property (off_go_wr |=> !CONV_START_O [*6])
        else $error("start pulse with converter off");
    start_power_a: assert property (CONV_START_O |-> CONV_POWER_O)
        else $error("start pulse without power");
    start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
        else $error("start pulse longer than one cycle");
    power_wr_a: assert property (wr0 |=> CONV_POWER_O == $past(WDATA_I[0]))
        else $error("power does not follow on bit");
    pos_sel_a: assert property (wr0 |=> POS_SEL_O == $past(WDATA_I[6:2]))
        else $error("positive select not taken");
    bit7_zero_a: assert property ($past(RD_I) && $past(ADDR_I) == 4'h0 |-> !RDATA_O[7])
        else $error("control zero bit 7 reads one");
    cfg_one_a: assert property (WR_I && ADDR_I == `OFS_CTRL_ONE |=>
        REF_TRIG_CFG_O == $past(WDATA_I) && NEG_SEL_O == $past(WDATA_I[2:0]))
        else $error("control one not taken");
    cfg_two_a: assert property (WR_I && ADDR_I == `OFS_CTRL_TWO |=>
        (CLK_ACQ_CFG_O & 8'hbf) == ($past(WDATA_I) & 8'hbf))
        else $error("control two not taken");
    neg_ground_a: assert property (NEG_GROUND_O == (NEG_SEL_O == 3'h0))
        else $error("ground tie wrong");
    internal_a: assert property (POS_INTERNAL_O == (POS_SEL_O >= `SEL_CHARGE))
        else $error("internal source flag wrong");
    pin_range_a: assert property (POS_PIN_O |-> POS_SEL_O <= `SEL_LAST_PIN)
        else $error("pin flag on a non-pin code");
endmodule

bind adc_channel_start_control adc_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CONV_POWER_O(CONV_POWER_O),
    .CONV_START_O(CONV_START_O), .POS_SEL_O(POS_SEL_O), .POS_PIN_O(POS_PIN_O),
    .POS_INTERNAL_O(POS_INTERNAL_O), .NEG_SEL_O(NEG_SEL_O),
    .NEG_GROUND_O(NEG_GROUND_O), .REF_TRIG_CFG_O(REF_TRIG_CFG_O),
    .CLK_ACQ_CFG_O(CLK_ACQ_CFG_O));

/* File: testbench/conv_core_model.sv */
// Behavioural model of the converter core on the far side
`timescale 1ns/1ps

module conv_core_model
(
    // Clock and control from the block
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        power_i,
    input  wire logic        start_i,
    // Settings from the bench
    input  wire logic [3:0]  lat_i,
    input  wire logic [11:0] val_i,
    input  wire logic        neg_i,
    // Answer to the block
    output logic             done_o,
    output logic [11:0]      result_o,
    output logic             sign_o
);
    logic [4:0] cnt_q;

    // Conversion time, then six cycles of done; power loss aborts
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= 5'h00;
        else if (!power_i)
            cnt_q <= 5'h00;
        else if (start_i && cnt_q == 5'h00)
            cnt_q <= {1'b0, lat_i} + 5'h07;
        else if (cnt_q != 5'h00)
            cnt_q <= cnt_q - 5'h01;
    end

    // Data only valid while done is high, inverted otherwise
    assign done_o   = cnt_q != 5'h00 && cnt_q <= 5'h06;
    assign result_o = done_o ? val_i : ~val_i;
    assign sign_o   = done_o ? neg_i : ~neg_i;
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module tb;
    localparam int SETTLE = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        neg = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [3:0]  lat = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic [11:0] val = 12'h000;
    logic        power, start, done, sgn, pos_pin, pos_int, neg_gnd, irq, fmt;
    logic [11:0] res;
    logic [4:0]  pos_sel, sel;
    logic [2:0]  neg_sel;
    logic [7:0]  rdata, ref_cfg, acq_cfg, got, hi, d;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed_v;

    // Clock
    always #2.5 clk = ~clk;

    adc_channel_start_control #(.SETTLE_CYCLES(SETTLE)) uut (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .CONV_POWER_O(power), .CONV_START_O(start),
        .CONV_DONE_I(done), .CONV_RESULT_I(res), .CONV_SIGN_I(sgn),
        .POS_SEL_O(pos_sel), .POS_PIN_O(pos_pin), .POS_INTERNAL_O(pos_int),
        .NEG_SEL_O(neg_sel), .NEG_GROUND_O(neg_gnd), .REF_TRIG_CFG_O(ref_cfg),
        .CLK_ACQ_CFG_O(acq_cfg), .IRQ_O(irq));

    conv_core_model core (
        .clk_i(clk), .rst_i(rst), .power_i(power), .start_i(start),
        .lat_i(lat), .val_i(val), .neg_i(neg), .done_o(done),
        .result_o(res), .sign_o(sgn));

    // Compare and bus tasks
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk);
        #1 chk({15'h0, irq}, {15'h0, e});
    endtask
    task automatic print_verdict();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected values
    function automatic logic pin_ok(input logic [4:0] c, input logic sm);
        pin_ok = c <= 5'h17 && !(sm && (c[4:2] == 3'h3 || c[4:2] == 3'h5));
    endfunction
    function automatic logic [15:0] just(input logic [11:0] v, input logic s, input logic r);
        just = r ? {{4{s}}, v} : {v, {4{s}}};
    endfunction

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        seed_v = $urandom(44);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
        begin
            rd_reg(a[3:0]);
            chk({8'h00, got}, 16'h0000);
        end
        chk({15'h0, neg_gnd}, 16'h0001);
        wr_reg(`OFS_IRQ_ENABLE, 8'h01);
        wr_reg(`OFS_CTRL_ZERO, 8'hfe);
        rd_reg(`OFS_CTRL_ZERO);
        chk({8'h00, got}, 16'h007c);
        chk({15'h0, irq}, 16'h0000);
        rd_reg(`OFS_IRQ_STATUS);
        chk({8'h00, got}, 16'h0002);
        wr_reg(`OFS_IRQ_ENABLE, 8'h03);
        irq_is(1'b1);
        wr_reg(`OFS_IRQ_CLEAR, 8'h02);
        irq_is(1'b0);
        // Every positive code on both package variants
        for (int p = 1; p >= 0; p--)
        begin
            wr_reg(`OFS_PKG_SEL, p[7:0]);
            for (int c = 0; c < 32; c++)
            begin
                wr_reg(`OFS_CTRL_ZERO, {1'b0, c[4:0], 2'h0});
                #1 chk({11'h0, pos_sel}, c[15:0]);
                chk({pos_pin, pos_int}, {pin_ok(c[4:0], p[0]), c >= 28});
            end
        end
        // Control one and two with random contents
        for (int i = 0; i < 12; i++)
        begin
            d = (i == 0) ? 8'h00 : 8'($urandom);
            wr_reg(`OFS_CTRL_ONE, d);
            rd_reg(`OFS_CTRL_ONE);
            chk({got, ref_cfg}, {d, d});
            chk({neg_gnd, neg_sel}, {d[2:0] == 3'h0, d[2:0]});
            wr_reg(`OFS_CTRL_TWO, d);
            rd_reg(`OFS_CTRL_TWO);
            chk({got, acq_cfg}, {d & 8'hbf, d & 8'hbf});
        end
        // Conversions with random data, format, channel and core delay
        wr_reg(`OFS_IRQ_ENABLE, 8'h01);
        for (int i = 0; i < 20; i++)
        begin
            val <= 12'($urandom);
            neg <= 1'($urandom);
            lat <= 4'($urandom);
            fmt = 1'($urandom);
            sel = (i < 2) ? {4'hf, i[0]} : 5'($urandom);
            wr_reg(`OFS_CTRL_TWO, {fmt, 7'h00});
            wr_reg(`OFS_CTRL_ZERO, {1'b0, sel, 2'h3});
            rd_reg(`OFS_CTRL_ZERO);
            chk({8'h00, got}, {9'h000, sel, 2'h3});
            for (int k = 0; k < 40 && got[1] === 1'b1; k++)
                rd_reg(`OFS_CTRL_ZERO);
            chk({8'h00, got}, {9'h000, sel, 2'h1});
            rd_reg(`OFS_RES_HIGH);
            hi = got;
            rd_reg(`OFS_RES_LOW);
            chk({hi, got}, just(val, neg, fmt));
            chk({15'h0, irq}, 16'h0001);
            wr_reg(`OFS_IRQ_CLEAR, 8'h01);
            irq_is(1'b0);
        end
        // Go while busy is ignored; clearing the on bit aborts with no result or flag
        lat <= 4'hf;
        wr_reg(`OFS_CTRL_ZERO, 8'h03);
        wr_reg(`OFS_CTRL_ZERO, 8'h03);
        rd_reg(`OFS_CTRL_ZERO);
        chk({8'h00, got}, 16'h0003);
        wr_reg(`OFS_CTRL_ZERO, 8'h00);
        #1 chk({15'h0, power}, 16'h0000);
        rd_reg(`OFS_CTRL_ZERO);
        chk({8'h00, got}, 16'h0000);
        rd_reg(`OFS_IRQ_STATUS);
        chk({8'h00, got}, 16'h0000);
        // Result pair holds plain data while the converter is off
        d = 8'($urandom);
        wr_reg(`OFS_RES_HIGH, d);
        wr_reg(`OFS_RES_LOW, ~d);
        rd_reg(`OFS_RES_HIGH);
        hi = got;
        rd_reg(`OFS_RES_LOW);
        chk({hi, got}, {d, ~d});
        print_verdict();
    end
endmodule
